/* hw/srls_top.v */
// Purpose: Selects the sources that set and reset the latch, with AXI4-Lite control registers.
// Assumes: Comparator outputs, input pin and divider pulse are synchronous to aclk.
// Notes: The soft pulse bits self-clear and read back as zero.
`timescale 1ns/10ps
`include "srls_map.vh"
module srls_top (
  input wire aclk,
  input wire aresetn,
  input wire [`SRLS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SRLS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire latch_input_pin,
  input wire latch_divider_pulse,
  input wire cmp1_out,
  input wire cmp2_out,
  output wire true_output_pin,
  output wire true_output_pin_oe,
  output wire inverted_output_pin,
  output wire inverted_output_pin_oe
);
  reg [7:0] latch_control_main_reg;
  reg [7:0] latch_source_enables_reg;
  reg [`SRLS_ADDR_W-1:0] awaddr_reg;
  reg aw_held_reg;
  reg [7:0] wdata_reg;
  reg wstrb0_reg;
  reg w_held_reg;
  reg soft_set_reg;
  reg soft_reset_reg;
  reg set_reg;
  reg reset_reg;
  wire latch_q;
  wire [7:0] en;
  wire do_write;
  wire [7:0] wsel;
  wire set_next;
  wire reset_next;
  wire [1:0] aw_sel;
  wire [1:0] ar_sel;
  wire [7:0] main_keep;

  // Register select codes; the status word is mapped but only readable.
  localparam SEL_NONE = 2'b00;
  localparam SEL_MAIN = 2'b01;
  localparam SEL_SRC = 2'b10;
  localparam SEL_STAT = 2'b11;

  // Decodes a word offset into a register select; unmapped offsets yield none.
  function [1:0] srls_dec;
    input [`SRLS_ADDR_W-1:0] a;
    begin
      if (a == `SRLS_OFF_MAIN) begin
        srls_dec = SEL_MAIN;
      end else if (a == `SRLS_OFF_SRC) begin
        srls_dec = SEL_SRC;
      end else if (a == `SRLS_OFF_STAT) begin
        srls_dec = SEL_STAT;
      end else begin
        srls_dec = SEL_NONE;
      end
    end
  endfunction

  // The enables are read straight from the register, so no second copy can drift from what software reads back.
  assign en = latch_source_enables_reg;
  // A write is applied only once both halves are held and the previous response has been taken.
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wsel = wdata_reg;
  assign aw_sel = srls_dec(awaddr_reg);
  assign ar_sel = srls_dec(s_axi_araddr);
  // The pulse bits are never stored, so they read back as zero and a later write cannot fire them again.
  assign main_keep = ~((8'h01 << `SRLS_B_PS) | (8'h01 << `SRLS_B_PR));

  // AXI4-Lite write: address and data are caught in either order, answered once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= `SRLS_OFF_MAIN;
      wdata_reg <= `SRLS_MAIN_RESET;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRLS_RESP_OKAY;
      latch_control_main_reg <= `SRLS_MAIN_RESET;
      latch_source_enables_reg <= `SRLS_SRC_RESET;
      soft_set_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else begin
      soft_set_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // A write to the read-only status word is refused like one to an unmapped offset.
        s_axi_bresp <= (aw_sel == SEL_MAIN || aw_sel == SEL_SRC) ? `SRLS_RESP_OKAY : `SRLS_RESP_SLVERR;
        if (wstrb0_reg && aw_sel == SEL_MAIN) begin
          latch_control_main_reg <= wsel & main_keep;
          soft_set_reg <= wsel[`SRLS_B_PS];
          soft_reset_reg <= wsel[`SRLS_B_PR];
        end
        if (wstrb0_reg && aw_sel == SEL_SRC) begin
          latch_source_enables_reg <= wsel;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read: one cycle after the address is taken the data stand until rready.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= {`SRLS_ZERO24, `SRLS_MAIN_RESET};
      s_axi_rresp <= `SRLS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SRLS_RESP_OKAY;
        if (ar_sel == SEL_MAIN) begin
          s_axi_rdata <= {`SRLS_ZERO24, latch_control_main_reg};
        end else if (ar_sel == SEL_SRC) begin
          s_axi_rdata <= {`SRLS_ZERO24, latch_source_enables_reg};
        end else if (ar_sel == SEL_STAT) begin
          s_axi_rdata <= {`SRLS_ZERO29, reset_reg, set_reg, latch_q};
        end else begin
          // Unmapped reads return zero with an error response.
          s_axi_rdata <= {`SRLS_ZERO24, 8'h00};
          s_axi_rresp <= `SRLS_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Sources are ORed combinationally and registered once, so every term reaches the latch one clock later.
  assign set_next = (en[`SRLS_B_PIN_SET] & latch_input_pin)
    | (en[`SRLS_B_CLK_SET] & latch_divider_pulse)
    | (en[`SRLS_B_C2_SET] & cmp2_out)
    | (en[`SRLS_B_C1_SET] & cmp1_out)
    | soft_set_reg;
  assign reset_next = (en[`SRLS_B_PIN_RST] & latch_input_pin)
    | (en[`SRLS_B_CLK_RST] & latch_divider_pulse)
    | (en[`SRLS_B_C2_RST] & cmp2_out)
    | (en[`SRLS_B_C1_RST] & cmp1_out)
    | soft_reset_reg;

  // One register stage between the OR tree and the latch keeps glitches of the sources off the latch inputs.
  always @(posedge aclk) begin
    if (!aresetn) begin
      set_reg <= 1'b0;
      reset_reg <= 1'b0;
    end else begin
      set_reg <= set_next;
      reset_reg <= reset_next;
    end
  end

  // Reset dominates inside the core, so a source that sets and resets at once leaves the latch cleared.
  srls_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(latch_control_main_reg[`SRLS_B_LEN]),
    .set_in(set_reg),
    .reset_in(reset_reg),
    .q_en(latch_control_main_reg[`SRLS_B_QEN]),
    .nq_en(latch_control_main_reg[`SRLS_B_NQEN]),
    .q(latch_q),
    .q_pin(true_output_pin),
    .q_pin_oe(true_output_pin_oe),
    .nq_pin(inverted_output_pin),
    .nq_pin_oe(inverted_output_pin_oe)
  );
endmodule // srls_top

/* hw/srls_map.vh */
// Purpose: Register offsets, field positions and reset values of the latch source select block.
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef SRLS_MAP_VH
`define SRLS_MAP_VH
`define SRLS_ADDR_W 4
`define SRLS_OFF_MAIN 4'h0
`define SRLS_OFF_SRC 4'h4
`define SRLS_OFF_STAT 4'h8
`define SRLS_MAIN_RESET 8'h00
`define SRLS_SRC_RESET 8'h00
`define SRLS_B_LEN 7
`define SRLS_B_QEN 3
`define SRLS_B_NQEN 2
`define SRLS_B_PS 1
`define SRLS_B_PR 0
`define SRLS_B_PIN_SET 7
`define SRLS_B_CLK_SET 6
`define SRLS_B_C2_SET 5
`define SRLS_B_C1_SET 4
`define SRLS_B_PIN_RST 3
`define SRLS_B_CLK_RST 2
`define SRLS_B_C2_RST 1
`define SRLS_B_C1_RST 0
`define SRLS_RESP_OKAY 2'b00
`define SRLS_RESP_SLVERR 2'b10
`define SRLS_ZERO24 24'h000000
`define SRLS_ZERO29 29'h00000000
`endif

/* hw/srls_core.v */
// Purpose: The set/reset latch itself with its output pin drivers.
// Assumes: Set and reset terms arrive as registered levels.
// Notes: Reset dominates when set and reset meet.
`timescale 1ns/10ps
module srls_core (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire set_in,
  input wire reset_in,
  input wire q_en,
  input wire nq_en,
  output reg q,
  output reg q_pin,
  output reg q_pin_oe,
  output reg nq_pin,
  output reg nq_pin_oe
);
  reg q_next;
  always @* begin
    q_next = q;
    if (!enable) begin
      q_next = 1'b0;
    end else if (reset_in) begin
      q_next = 1'b0;
    end else if (set_in) begin
      q_next = 1'b1;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
      q_pin <= 1'b0;
      q_pin_oe <= 1'b0;
      nq_pin <= 1'b0;
      nq_pin_oe <= 1'b0;
    end else begin
      q <= q_next;
      q_pin <= q_next;
      nq_pin <= ~q_next;
      q_pin_oe <= enable & q_en;
      nq_pin_oe <= enable & nq_en;
    end
  end
endmodule // srls_core

/* testbench/srls_props.sv */
// Purpose: Port-level assertions for srls_top.
// Assumes: The bench offers write address and data in the same cycle.
// Notes: The source enables are shadowed from bus writes, because only the ports are visible here.
`timescale 1ns/10ps
`include "srls_map.vh"
module srls_props (
  input wire aclk,
  input wire aresetn,
  input wire [`SRLS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire latch_input_pin,
  input wire latch_divider_pulse,
  input wire cmp1_out,
  input wire cmp2_out,
  input wire true_output_pin,
  input wire true_output_pin_oe,
  input wire inverted_output_pin,
  input wire inverted_output_pin_oe
);
  reg [7:0] src_reg;
  reg [7:0] main_sh_reg;
  wire q_drive = main_sh_reg[`SRLS_B_LEN] && main_sh_reg[`SRLS_B_QEN];
  wire nq_drive = main_sh_reg[`SRLS_B_LEN] && main_sh_reg[`SRLS_B_NQEN];
  wire wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  wire [3:0] src_in = {latch_input_pin, latch_divider_pulse, cmp2_out, cmp1_out};
  wire [3:0] rsrc = src_reg[3:0] & src_in;
  wire [3:0] ssrc = src_reg[7:4] & src_in;
  wire quiet = !(|rsrc) && !(|ssrc) && !s_axi_wvalid;
  wire lo = !true_output_pin || !true_output_pin_oe;
  wire hi = true_output_pin || !true_output_pin_oe;
  always @(posedge aclk) begin
    if (!aresetn)
      src_reg <= 8'h00;
    else if (wtake && s_axi_awaddr == `SRLS_OFF_SRC)
      src_reg <= s_axi_wdata[7:0];
  end
  always @(posedge aclk) begin
    if (!aresetn)
      main_sh_reg <= 8'h00;
    else if (wtake && s_axi_awaddr == `SRLS_OFF_MAIN)
      main_sh_reg <= s_axi_wdata[7:0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence soft_set_wr;
    wtake && s_axi_awaddr == `SRLS_OFF_MAIN && s_axi_wdata[7:0] == 8'h8a && !(|rsrc);
  endsequence
  sequence soft_rst_wr;
    wtake && s_axi_awaddr == `SRLS_OFF_MAIN && s_axi_wdata[7:0] == 8'h89 && !(|ssrc);
  endsequence
  pin_reset_a: assert property (rsrc[3] |-> ##2 lo)
    else $error("pin reset missed");
  clock_reset_a: assert property (rsrc[2] |-> ##2 lo)
    else $error("divider reset missed");
  cmp2_reset_a: assert property (rsrc[1] |-> ##2 lo)
    else $error("cmp2 reset missed");
  cmp2_set_a: assert property (ssrc[1] && !(|rsrc) |-> ##2 hi)
    else $error("cmp2 set missed");
  cmp1_set_a: assert property (ssrc[0] && !(|rsrc) |-> ##2 hi)
    else $error("cmp1 set missed");
  quiet_hold_a: assert property (quiet [*5] |=> $stable(true_output_pin))
    else $error("pin moved without a source");
  soft_set_a: assert property (soft_set_wr |-> ##[3:6] true_output_pin)
    else $error("soft set missed");
  soft_reset_a: assert property (soft_rst_wr |-> ##[3:6] !true_output_pin)
    else $error("soft reset missed");
  pin_set_a: assert property (ssrc[3] && !(|rsrc) |-> ##2 hi)
    else $error("pin set missed");
  cmp1_reset_a: assert property (rsrc[0] |-> ##2 lo)
    else $error("cmp1 reset missed");
  true_oe_a: assert property (true_output_pin_oe == $past(q_drive, 2))
    else $error("true output enable wrong");
  inv_oe_a: assert property (inverted_output_pin_oe == $past(nq_drive, 2))
    else $error("inverted output enable wrong");
endmodule // srls_props
bind srls_top srls_props chk (.*);

/* testbench/srls_far.sv */
// Purpose: Far side model: comparator outputs, input pin and divider pulse.
// Assumes: All four are synchronous to aclk and change at the rising edge.
// Notes: Slow mode lags one extra cycle, as a sluggish comparator would.
`timescale 1ns/10ps
module srls_far (
  input wire aclk,
  input wire slow,
  input wire [3:0] drive,
  output reg latch_input_pin,
  output reg latch_divider_pulse,
  output reg cmp2_out,
  output reg cmp1_out
);
  reg [3:0] lag_reg = 4'h0;
  initial {latch_input_pin, latch_divider_pulse, cmp2_out, cmp1_out} = 4'h0;
  always @(posedge aclk) begin
    lag_reg <= drive;
    {latch_input_pin, latch_divider_pulse, cmp2_out, cmp1_out} <= slow ? lag_reg : drive;
  end
endmodule // srls_far

/* testbench/sr_latch_source_select_tb.sv */
// Purpose: Self-checking bench for srls_top.
// Assumes: The latch state shows on the true output pin within six cycles of an event.
// Notes: Sources pulse for one cycle only, so level and pulse sources share one table.
`timescale 1ns/10ps
`include "srls_map.vh"
module sr_latch_source_select_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow;
  logic [3:0] s_axi_awaddr, s_axi_araddr, drive;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire latch_input_pin, latch_divider_pulse, cmp1_out, cmp2_out;
  wire true_output_pin, true_output_pin_oe, inverted_output_pin, inverted_output_pin_oe;
  integer error_cnt, samples_checked, i;
  srls_top dut (.*);
  srls_far far (.aclk(aclk), .slow(slow), .drive(drive), .latch_input_pin(latch_input_pin),
    .latch_divider_pulse(latch_divider_pulse), .cmp2_out(cmp2_out), .cmp1_out(cmp1_out));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task chk(input [33:0] g, input [33:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({32'h0, s_axi_bresp}, {32'h0, er});
    end
  endtask
  task rdchk(input [3:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, s_axi_rdata}, {er, e});
    end
  endtask
  task pulse(input integer k);
    begin
      @(posedge aclk);
      drive <= 4'h1 << k;
      @(posedge aclk);
      drive <= 4'h0;
    end
  endtask
  task qchk(input [1:0] e);
    begin
      repeat (6) @(posedge aclk);
      chk({32'h0, true_output_pin_oe, true_output_pin}, {32'h0, e});
      chk({32'h0, inverted_output_pin_oe, inverted_output_pin}, {32'h0, 1'b0, ~e[0]});
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, drive, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hf;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`SRLS_OFF_MAIN, 32'h0, `SRLS_RESP_OKAY);
    rdchk(`SRLS_OFF_SRC, 32'h0, `SRLS_RESP_OKAY);
    wr(`SRLS_OFF_SRC, 8'ha5, `SRLS_RESP_OKAY);
    rdchk(`SRLS_OFF_SRC, 32'ha5, `SRLS_RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(`SRLS_OFF_SRC, 8'h5a, `SRLS_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdchk(`SRLS_OFF_SRC, 32'ha5, `SRLS_RESP_OKAY);
    wr(4'hc, 8'hff, `SRLS_RESP_SLVERR);
    rdchk(4'hc, 32'h0, `SRLS_RESP_SLVERR);
    // Start from the opposite state, so a source that never reaches the latch is seen.
    for (i = 0; i < 8; i = i + 1) begin
      slow <= i[0];
      wr(`SRLS_OFF_MAIN, (i < 4) ? 8'h8a : 8'h89, `SRLS_RESP_OKAY);
      wr(`SRLS_OFF_SRC, 8'h00, `SRLS_RESP_OKAY);
      pulse(i % 4);
      qchk({1'b1, i < 4});
      wr(`SRLS_OFF_SRC, 8'h01 << i, `SRLS_RESP_OKAY);
      pulse(i % 4);
      qchk({1'b1, i >= 4});
    end
    wr(`SRLS_OFF_MAIN, 8'h88, `SRLS_RESP_OKAY);
    qchk(2'h3);
    rdchk(`SRLS_OFF_MAIN, 32'h88, `SRLS_RESP_OKAY);
    rdchk(`SRLS_OFF_STAT, 32'h1, `SRLS_RESP_OKAY);
    wr(`SRLS_OFF_STAT, 8'h00, `SRLS_RESP_SLVERR);
    rdchk(`SRLS_OFF_STAT, 32'h1, `SRLS_RESP_OKAY);
    wr(`SRLS_OFF_MAIN, 8'h80, `SRLS_RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk({32'h0, true_output_pin_oe, inverted_output_pin_oe}, 34'h0);
    wr(`SRLS_OFF_MAIN, 8'h84, `SRLS_RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk({31'h0, inverted_output_pin_oe, inverted_output_pin, true_output_pin_oe}, 34'h4);
    wr(`SRLS_OFF_MAIN, 8'h08, `SRLS_RESP_OKAY);
    qchk(2'h0);
    conclude;
  end
endmodule // sr_latch_source_select_tb
